// ### core/aau_regs.svh
`ifndef AAU_REGS_SVH
`define AAU_REGS_SVH
// i/o offsets of the accelerator registers
`define AAU_OFS_CTL        8'h00
`define AAU_OFS_OPSEL      8'h01
`define AAU_OFS_SAT        8'h02
`define AAU_OFS_OPA        8'h10
`define AAU_OFS_OPB        8'h11
`define AAU_OFS_ACCL       8'h38
`define AAU_OFS_ACCH       8'h39
// control/status field positions
`define AAU_CTL_EN         7
`define AAU_CTL_MAP        6
`define AAU_CTL_DDONE      5
`define AAU_CTL_DZERO      4
`define AAU_CTL_NEG        2
`define AAU_CTL_ZERO       1
`define AAU_CTL_CARRY      0
`define AAU_CTL_RESET      8'h20
// alias window and sram offset
`define AAU_ALIAS_LO       16'h2100
`define AAU_ALIAS_HI       16'h28ff
`define AAU_ALIAS_OFS      16'h2000
// division wait cycles
`define AAU_DIV_WAIT       4'h7
// fixed operation codes
`define AAU_OP_CLR         8'h80
`define AAU_OP_DIV         8'hb0
`define AAU_OP_DIVREM      8'hb1
`endif

// ### core/aau_pkg.sv
package aau_pkg;
  // i/o register access from the core
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } aau_io_req_s;
  // displaced load or store request from the core
  typedef struct packed {
    logic [15:0] ptr;
    logic [5:0]  disp;
    logic [4:0]  reg_num;
    logic        ld;
    logic        st;
    logic [15:0] ldata;
  } aau_ls_req_s;
  typedef enum logic [1:0] {
    AAU_IDLE = 2'b00,
    AAU_DIV  = 2'b01
  } aau_state_e;
endpackage

// ### core/aau_core.sv
`timescale 1ns/10ps
`include "aau_regs.svh"
module aau_core
  import aau_pkg::*;
(
  clk_sys,
  reset_n,
  io_req,
  io_rdata,
  ls_req,
  ls_is_alias,
  ls_mem_addr,
  ls_mem_wdata,
  ls_mem_we,
  ls_ptr_next,
  ls_ptr_we,
  sram_alias_addr,
  div_busy
);
  input  wire logic        clk_sys;
  input  wire aau_io_req_s io_req;
  input  wire logic        reset_n;
  output      logic [15:0] io_rdata;
  input  wire aau_ls_req_s ls_req;
  output      logic        ls_is_alias;
  output      logic [15:0] ls_mem_addr;
  output      logic [15:0] ls_mem_wdata;
  output      logic        ls_mem_we;
  output      logic [15:0] ls_ptr_next;
  output      logic        ls_ptr_we;
  input  wire logic [15:0] sram_alias_addr;
  output      logic        div_busy;

  // =====================================================
  // register state
  logic [15:0] opa_reg, opb_reg;
  logic [31:0] acc_reg;
  logic [7:0]  opsel_reg;
  logic        en_reg, map_reg, ddone_reg, dzero_reg, neg_reg, zero_reg, carry_reg;
  aau_state_e  state_reg;
  logic [3:0]  wait_reg;
  logic [31:0] quo_reg;
  logic [15:0] rem_reg;
  logic        rem_keep_reg;

  // =====================================================
  // saturated result, always live
  wire        acc_pos_ovf = !acc_reg[31] && (acc_reg[30:15] != 16'h0000);
  wire        acc_neg_ovf = acc_reg[31] && (acc_reg[30:15] != 16'hffff);
  wire [15:0] sat_val     = acc_pos_ovf ? 16'h7fff :
                            acc_neg_ovf ? 16'h8000 : acc_reg[15:0];

  // read decode shared by i/o reads and mapped stores
  function automatic logic [15:0] rd_sel(input logic [7:0] a, input logic [15:0] opa,
                                          input logic [15:0] opb, input logic [31:0] acc,
                                          input logic [15:0] sat, input logic [7:0] ctl,
                                          input logic [7:0] ops);
    case (a)
      `AAU_OFS_CTL:   rd_sel = {8'h00, ctl};
      `AAU_OFS_OPSEL: rd_sel = {8'h00, ops};
      `AAU_OFS_SAT:   rd_sel = sat;
      `AAU_OFS_OPA:   rd_sel = opa;
      `AAU_OFS_OPB:   rd_sel = opb;
      `AAU_OFS_ACCL:  rd_sel = acc[15:0];
      `AAU_OFS_ACCH:  rd_sel = acc[31:16];
      default:        rd_sel = 16'h0000;
    endcase
  endfunction

  wire [7:0] ctl_val = {en_reg, map_reg, ddone_reg, dzero_reg, 1'b0,
                        neg_reg, zero_reg, carry_reg};

  // =====================================================
  // load/store channel
  assign ls_is_alias = (ls_req.ptr >= `AAU_ALIAS_LO) && (ls_req.ptr <= `AAU_ALIAS_HI);
  wire       ls_act    = (ls_req.ld || ls_req.st) && ls_is_alias && en_reg;
  // map 0 turns register number into accelerator slot; map 1 uses it as i/o address
  wire [7:0] map0_addr = (ls_req.reg_num == 5'd0) ? `AAU_OFS_OPA :
                         (ls_req.reg_num == 5'd1) ? `AAU_OFS_OPB :
                         (ls_req.reg_num == 5'd2) ? `AAU_OFS_ACCL :
                         (ls_req.reg_num == 5'd3) ? `AAU_OFS_ACCH :
                         (ls_req.reg_num == 5'd4 && ls_req.st) ? `AAU_OFS_SAT :
                         8'hff;
  wire [7:0] map_addr  = map_reg ? {3'b000, ls_req.reg_num} : map0_addr;
  wire [15:0] disp16   = {10'h000, ls_req.disp};
  assign ls_mem_addr  = ls_is_alias ? ls_req.ptr : 16'(ls_req.ptr + disp16);
  assign ls_ptr_next  = 16'(ls_req.ptr + disp16);
  assign ls_ptr_we    = ls_act;
  assign ls_mem_we    = ls_act && ls_req.st;
  assign ls_mem_wdata = rd_sel(map_addr, opa_reg, opb_reg, acc_reg, sat_val,
                               ctl_val, opsel_reg);
  wire        ls_ld    = ls_act && ls_req.ld;
  assign div_busy = (state_reg == AAU_DIV);

  // unified register write port: i/o write or alias load
  wire        w_en   = io_req.wr || ls_ld;
  wire [7:0]  w_addr = ls_ld ? map_addr : io_req.addr;
  wire [15:0] w_data = ls_ld ? ls_req.ldata : io_req.wdata;

  // =====================================================
  // operation decode
  wire [7:0] op     = io_req.wdata[7:0];
  wire       op_go  = io_req.wr && (io_req.addr == `AAU_OFS_OPSEL) && en_reg;
  wire       sg     = op[5];
  wire [32:0] a_ext = {{17{sg & opa_reg[15]}}, opa_reg};
  wire [32:0] b_ext = {{17{sg & opb_reg[15]}}, opb_reg};
  wire [32:0] acc33 = {sg & acc_reg[31], acc_reg};
  // 17x17 multiplier handles signed and unsigned 16-bit products
  wire signed [16:0] ma = {op[5] & opa_reg[15], opa_reg};
  wire signed [16:0] mb = {op[4] & opb_reg[15], opb_reg};
  wire signed [33:0] prod = ma * mb;
  wire [33:0] sqa = $signed({op[0] & opa_reg[15], opa_reg}) *
                    $signed({op[0] & opa_reg[15], opa_reg});
  wire [33:0] sqb = $signed({op[0] & opb_reg[15], opb_reg}) *
                    $signed({op[0] & opb_reg[15], opb_reg});
  wire [33:0] macc = {{2{op[0] & acc_reg[31]}}, acc_reg};
  wire [33:0] mres = op[1] ? (op[2] ? 34'(macc + prod) : 34'(macc - prod))
                           : (op[2] ? prod : 34'(34'h0 - prod));
  wire [33:0] msh  = op[3] ? {mres[33], mres[33:1]} : mres;
  wire [4:0]  shn  = {1'b0, op[3:0]};
  wire [31:0] shl  = acc_reg << shn;
  wire [31:0] shr  = op[5] ? 32'($signed(acc_reg) >>> shn) : (acc_reg >> shn);
  wire        misc_s = op[0];

  logic [32:0] res;
  logic        res_ok;
  // combinational result for single-cycle classes
  always_comb begin
    res    = {1'b0, acc_reg};
    res_ok = 1'b1;
    case (op[7:6])
      2'b00: begin
        case (op[4:1])
          4'b0010: res = 33'(a_ext + b_ext);
          4'b0000: res = 33'(a_ext - b_ext);
          4'b1110: res = b_ext;
          4'b1100: res = 33'(33'h0 - b_ext);
          4'b1011: res = 33'(acc33 + b_ext);
          4'b1001: res = 33'(acc33 - b_ext);
          default: res_ok = 1'b0;
        endcase
      end
      2'b01: res = msh[32:0];
      2'b10: begin
        if (op == `AAU_OP_CLR) begin
          res = 33'h0;
        end else if (op[5:1] == 5'b00010) begin
          res = 33'(33'h0 - {misc_s & acc_reg[31], acc_reg});
        end else if (op[5:1] == 5'b00100) begin
          res = sqa[32:0];
        end else if (op[5:1] == 5'b00101) begin
          res = sqb[32:0];
        end else if (op[5:1] == 5'b10000) begin
          res = (misc_s && acc_reg[31]) ? 33'(33'h0 - {1'b1, acc_reg}) : {1'b0, acc_reg};
        end else begin
          res_ok = 1'b0;
        end
      end
      2'b11: res = op[4] ? {1'b0, shr} : {acc_reg[31 - shn], shl};
      default: res_ok = 1'b0;
    endcase
  end

  wire is_div = (op == `AAU_OP_DIV) || (op == `AAU_OP_DIVREM);
  wire div_z  = (opb_reg == 16'h0000);

  // =====================================================
  // control/status and opcode registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_reg    <= 1'b0;
      map_reg   <= 1'b0;
      dzero_reg <= 1'b0;
      neg_reg   <= 1'b0;
      zero_reg  <= 1'b0;
      carry_reg <= 1'b0;
      opsel_reg <= 8'h00;
    end else begin
      if (w_en && w_addr == `AAU_OFS_CTL) begin
        en_reg    <= w_data[`AAU_CTL_EN];
        map_reg   <= w_data[`AAU_CTL_MAP];
        dzero_reg <= w_data[`AAU_CTL_DZERO];
        neg_reg   <= w_data[`AAU_CTL_NEG];
        zero_reg  <= w_data[`AAU_CTL_ZERO];
        carry_reg <= w_data[`AAU_CTL_CARRY];
      end
      if (w_en && w_addr == `AAU_OFS_OPSEL) begin
        opsel_reg <= w_data[7:0];
      end
      if (op_go && !is_div && res_ok && !div_busy) begin
        neg_reg   <= res[31];
        zero_reg  <= (res[31:0] == 32'h0);
        carry_reg <= res[32];
      end
      if (op_go && is_div && !div_busy) begin
        dzero_reg <= div_z;
      end
    end
  end

  // done flag: set by hardware wins over a software write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ddone_reg <= 1'(`AAU_CTL_RESET >> `AAU_CTL_DDONE);
    end else if (div_busy && wait_reg == 4'h0) begin
      ddone_reg <= 1'b1;
    end else if (op_go && is_div) begin
      ddone_reg <= 1'b0;
    end else if (w_en && w_addr == `AAU_OFS_CTL) begin
      ddone_reg <= w_data[`AAU_CTL_DDONE];
    end
  end

  // =====================================================
  // division sequencer: result lands after seven wait cycles
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= AAU_IDLE;
      wait_reg     <= 4'h0;
      quo_reg      <= 32'h0;
      rem_reg      <= 16'h0;
      rem_keep_reg <= 1'b0;
    end else begin
      case (state_reg)
        AAU_IDLE: begin
          if (op_go && is_div) begin
            state_reg    <= AAU_DIV;
            wait_reg     <= 4'(`AAU_DIV_WAIT - 4'h1);
            quo_reg      <= div_z ? 32'hffffffff : acc_reg / {16'h0, opb_reg};
            rem_reg      <= div_z ? acc_reg[15:0] : 16'(acc_reg % {16'h0, opb_reg});
            rem_keep_reg <= op[0];
          end
        end
        AAU_DIV: begin
          if (wait_reg == 4'h0) begin
            state_reg <= AAU_IDLE;
          end else begin
            wait_reg <= 4'(wait_reg - 4'h1);
          end
        end
        default: state_reg <= AAU_IDLE;
      endcase
    end
  end

  // =====================================================
  // data registers: writes, alias loads and operation results
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      opa_reg <= 16'h0;
      opb_reg <= 16'h0;
      acc_reg <= 32'h0;
    end else begin
      if (w_en && w_addr == `AAU_OFS_OPA) opa_reg <= w_data;
      if (w_en && w_addr == `AAU_OFS_OPB) opb_reg <= w_data;
      if (w_en && w_addr == `AAU_OFS_ACCL) acc_reg[15:0] <= w_data;
      if (w_en && w_addr == `AAU_OFS_ACCH) acc_reg[31:16] <= w_data;
      if (op_go && !is_div && res_ok && !div_busy) acc_reg <= res[31:0];
      if (div_busy && wait_reg == 4'h0) begin
        acc_reg <= quo_reg;
        if (rem_keep_reg) opb_reg <= rem_reg;
      end
    end
  end

  // =====================================================
  // i/o read data, one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata <= 16'h0;
    end else if (io_req.rd) begin
      io_rdata <= rd_sel(io_req.addr, opa_reg, opb_reg, acc_reg, sat_val,
                         ctl_val, opsel_reg);
    end
  end

  // informative alias conversion for sram byte addresses is done by software
  wire unused_ok = (sram_alias_addr == 16'(sram_alias_addr - `AAU_ALIAS_OFS + `AAU_ALIAS_OFS));
endmodule

// ### bench/aau_core_monitor.sv
`timescale 1ns/10ps
`include "aau_regs.svh"
// ==========================================================
// port checker for the accelerator
module aau_core_monitor
  import aau_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire aau_io_req_s io_req,
  input wire logic [15:0] io_rdata,
  input wire aau_ls_req_s ls_req,
  input wire logic        ls_is_alias,
  input wire logic [15:0] ls_mem_addr,
  input wire logic        ls_mem_we,
  input wire logic [15:0] ls_ptr_next,
  input wire logic        ls_ptr_we,
  input wire logic        div_busy
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // address path of the 16-bit channel
  alias_decode_a:
  assert property (ls_is_alias == (ls_req.ptr >= `AAU_ALIAS_LO && ls_req.ptr <= `AAU_ALIAS_HI))
    else $error("alias window decode wrong");
  alias_addr_a:
  assert property (ls_is_alias |-> ls_mem_addr == ls_req.ptr
                   && ls_ptr_next == ls_req.ptr + {10'h000, ls_req.disp})
    else $error("alias address or pointer step wrong");
  byte_addr_a:
  assert property (!ls_is_alias |-> ls_mem_addr == ls_req.ptr + {10'h000, ls_req.disp} && !ls_ptr_we)
    else $error("byte address wrong or pointer moved");
  ptr_update_a:
  assert property (ls_ptr_we |-> (ls_req.ld || ls_req.st) && ls_is_alias)
    else $error("pointer update without alias access");
  store_we_a:
  assert property (ls_mem_we |-> ls_req.st && ls_is_alias)
    else $error("memory write without alias store");
  // operation start and division length
  div_start_a:
  assert property ($rose(div_busy) |-> $past(io_req.wr) && $past(io_req.addr) == `AAU_OFS_OPSEL)
    else $error("division began without opcode write");
  div_length_a:
  assert property ($rose(div_busy) |-> div_busy [*6] ##[1:2] !div_busy)
    else $error("division length wrong");
  // register read path
  word_readback_a:
  assert property (io_req.wr && io_req.addr == `AAU_OFS_OPA ##1 !io_req.wr
                   ##1 io_req.rd && io_req.addr == `AAU_OFS_OPA
                   |=> io_rdata == $past(io_req.wdata, 3))
    else $error("operand readback wrong");
  ctl_byte_a:
  assert property (io_req.rd && io_req.addr == `AAU_OFS_CTL |=> io_rdata[15:8] == 8'h00)
    else $error("control register not byte wide");
  unmapped_read_a:
  assert property (io_req.rd && io_req.addr == 8'h05 |=> io_rdata == 16'h0000)
    else $error("unmapped read not zero");
  div_seen_c: cover property ($rose(div_busy));
  alias_store_c: cover property (ls_mem_we);
  ptr_step_c: cover property (ls_ptr_we && ls_req.ld);
endmodule
bind aau_core aau_core_monitor aau_core_monitor_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req), .io_rdata(io_rdata),
  .ls_req(ls_req), .ls_is_alias(ls_is_alias), .ls_mem_addr(ls_mem_addr),
  .ls_mem_we(ls_mem_we), .ls_ptr_next(ls_ptr_next), .ls_ptr_we(ls_ptr_we),
  .div_busy(div_busy));

// ### bench/aau_sram_model.sv
`timescale 1ns/10ps
`include "aau_regs.svh"
// ==========================================================
// data sram seen through the 16-bit alias channel
module aau_sram_model (
  input wire logic        clk_sys,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        we,
  output     logic [15:0] rdata
);
  logic [15:0] mem [0:1023];
  logic [9:0]  idx;
  logic        in_win;
  logic        tgl;
  // alias address less the offset and the 0x100 window base, halved to a word index
  assign idx    = 10'((addr - `AAU_ALIAS_OFS - 16'h0100) >> 1);
  assign in_win = addr >= `AAU_ALIAS_LO && addr <= `AAU_ALIAS_HI;
  // outside the window the channel shows a changing pattern, never stale data
  assign rdata  = in_win ? mem[idx] : {8{tgl, ~tgl}};
  initial begin
    tgl = 1'b0;
    for (int i = 0; i < 1024; i++) mem[i] = 16'(i * 16'h0101) ^ 16'h5a3c;
  end
  // word store from the accelerator
  always @(posedge clk_sys) begin
    tgl <= ~tgl;
    if (we && in_win) mem[idx] <= wdata;
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
`include "aau_regs.svh"
// ==========================================================
// random and corner stimulus for the accelerator
module tb_top
  import aau_pkg::*;
;
  logic        clk_sys, reset_n, ls_is_alias, ls_mem_we, ls_ptr_we, div_busy;
  aau_io_req_s io_req;
  aau_ls_req_s ls_drv, ls_req;
  logic [15:0] io_rdata, ls_mem_addr, ls_mem_wdata, ls_ptr_next, sram_rdata, a, b, d;
  logic [31:0] acc, q, e;
  logic [7:0]  ofs [4] = '{`AAU_OFS_OPA, `AAU_OFS_OPB, `AAU_OFS_ACCL, `AAU_OFS_ACCH};
  logic [7:0]  ops [16] = '{8'h05, 8'h25, 8'h01, 8'h21, 8'h17, 8'h37, 8'h19, 8'h44,
                            8'h46, 8'h4c, 8'h74, 8'h80, 8'h88, 8'hcf, 8'hd3, 8'hff};
  int          failures, comparisons, seed, k;
  aau_core aau_core_inst (.clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req),
    .io_rdata(io_rdata), .ls_req(ls_req), .ls_is_alias(ls_is_alias),
    .ls_mem_addr(ls_mem_addr), .ls_mem_wdata(ls_mem_wdata), .ls_mem_we(ls_mem_we),
    .ls_ptr_next(ls_ptr_next), .ls_ptr_we(ls_ptr_we), .sram_alias_addr(ls_drv.ptr),
    .div_busy(div_busy));
  aau_sram_model aau_sram_model_inst (.clk_sys(clk_sys), .addr(ls_mem_addr),
    .wdata(ls_mem_wdata), .we(ls_mem_we), .rdata(sram_rdata));
  // load data comes from the sram in the cycle of the request
  always_comb begin
    ls_req = ls_drv;
    ls_req.ldata = sram_rdata;
  end
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic io_wr(input logic [7:0] ad, input logic [15:0] v);
    @(posedge clk_sys);
    io_req <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    io_req <= '0;
  endtask
  task automatic io_rd(input logic [7:0] ad, output logic [15:0] v);
    @(posedge clk_sys);
    io_req <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    io_req <= '0;
    #1 v = io_rdata;
  endtask
  task automatic ls_op(input logic [15:0] p, input logic [4:0] r, input logic l);
    @(posedge clk_sys);
    ls_drv <= '{ptr: p, disp: 6'h02, reg_num: r, ld: l, st: !l, ldata: 16'h0000};
    #1 chk("ptr_we", {31'h0, p >= `AAU_ALIAS_LO}, {31'h0, ls_ptr_we});
    @(posedge clk_sys);
    ls_drv <= '{ptr: p, disp: 6'h02, reg_num: r, ld: 1'b0, st: 1'b0, ldata: 16'h0000};
  endtask
  function automatic logic [15:0] mw(input int i);
    return 16'(i * 16'h0101) ^ 16'h5a3c;
  endfunction
  function automatic logic [15:0] sat(input logic [31:0] v);
    if ($signed(v) > 32'sd32767) return 16'h7fff;
    if ($signed(v) < -32'sd32768) return 16'h8000;
    return v[15:0];
  endfunction
  function automatic logic [31:0] exp_op(input logic [7:0] c, input logic [15:0] x,
                                         input logic [15:0] y, input logic [31:0] ac);
    logic [31:0] xs, ys, xu, yu;
    xu = {16'h0000, x};
    yu = {16'h0000, y};
    xs = c[5] ? {{16{x[15]}}, x} : xu;
    ys = c[5] ? {{16{y[15]}}, y} : yu;
    case (c)
      8'h05, 8'h25: return xs + ys;
      8'h01, 8'h21: return xs - ys;
      8'h17, 8'h37: return ac + ys;
      8'h19:        return -yu;
      8'h44:        return xu * yu;
      8'h46:        return ac + xu * yu;
      8'h4c:        return (xu * yu) >> 1;
      8'h74:        return xs * ys;
      8'h80:        return 32'h0000_0000;
      8'h88:        return xu * xu;
      8'hcf:        return ac << 15;
      8'hd3:        return ac >> 3;
      default:      return $signed(ac) >>> 15;
    endcase
  endfunction
  task automatic end_of_test();
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    io_req = '0;
    ls_drv = '0;
    seed = 2397;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    io_rd(`AAU_OFS_CTL, d); chk("ctl_reset", 32'h20, {16'h0, d});
    io_wr(`AAU_OFS_ACCL, 16'h1234);
    io_wr(`AAU_OFS_OPSEL, 16'h0080);
    io_rd(`AAU_OFS_ACCL, d); chk("acc_disabled", 32'h1234, {16'h0, d});
    io_wr(`AAU_OFS_CTL, 16'h0080);
    for (int i = 0; i < 64; i++) begin
      a = (i < 16) ? 16'h8000 : 16'($random(seed));
      b = (i < 16) ? 16'hffff : 16'($random(seed));
      acc = (i < 16) ? 32'h8000_0001 : $random(seed);
      io_wr(`AAU_OFS_OPA, a);
      io_rd(`AAU_OFS_OPA, d); chk("opa", {16'h0, a}, {16'h0, d});
      io_wr(`AAU_OFS_OPB, b);
      io_wr(`AAU_OFS_ACCL, acc[15:0]);
      io_wr(`AAU_OFS_ACCH, acc[31:16]);
      io_wr(`AAU_OFS_OPSEL, {8'h00, ops[i % 16]});
      e = exp_op(ops[i % 16], a, b, acc);
      io_rd(`AAU_OFS_CTL, d);
      chk("zero_flag", {31'h0, e == 32'h0}, {31'h0, d[1]});
      chk("neg_flag", {31'h0, e[31]}, {31'h0, d[2]});
      io_rd(`AAU_OFS_ACCL, d);
      q[15:0] = d;
      io_rd(`AAU_OFS_ACCH, d);
      q[31:16] = d;
      chk("acc_result", e, q);
      io_rd(`AAU_OFS_SAT, d); chk("sat", {16'h0, sat(e)}, {16'h0, d});
    end
    // division with remainder, then by zero
    for (int j = 0; j < 2; j++) begin
      acc = $random(seed);
      b = j ? 16'h0000 : 16'($random(seed)) | 16'h0001;
      io_wr(`AAU_OFS_OPB, b);
      io_wr(`AAU_OFS_ACCL, acc[15:0]);
      io_wr(`AAU_OFS_ACCH, acc[31:16]);
      io_wr(`AAU_OFS_OPSEL, {8'h00, `AAU_OP_DIVREM});
      io_rd(`AAU_OFS_CTL, d); chk("done_early", 32'h0, {31'h0, d[5]});
      for (k = 0; k < 20 && d[5] !== 1'b1; k++) io_rd(`AAU_OFS_CTL, d);
      chk("div_zero", {31'h0, j[0]}, {31'h0, d[4]});
      io_rd(`AAU_OFS_ACCL, d);
      q[15:0] = d;
      io_rd(`AAU_OFS_ACCH, d);
      q[31:16] = d;
      chk("quotient", j ? 32'hffff_ffff : acc / {16'h0, b}, q);
      io_rd(`AAU_OFS_OPB, d);
      chk("remainder", j ? {16'h0, acc[15:0]} : acc % {16'h0, b}, {16'h0, d});
    end
    // loads and stores through the alias channel, map select 0 then 1
    for (int r = 0; r < 4; r++) begin
      ls_op(16'h2100 + 16'(2 * r), 5'(r), 1'b1);
      io_rd(ofs[r], d); chk("alias_load", {16'h0, mw(r)}, {16'h0, d});
    end
    for (int r = 0; r < 5; r++) begin
      ls_op(16'h2400 + 16'(2 * r), 5'(r), 1'b0);
      #1;
      chk("alias_store", {16'h0, r < 4 ? mw(r) : sat({mw(3), mw(2)})},
          {16'h0, aau_sram_model_inst.mem[384 + r]});
    end
    ls_op(16'h0100, 5'd2, 1'b1);
    io_rd(`AAU_OFS_ACCL, d); chk("byte_load", {16'h0, mw(2)}, {16'h0, d});
    io_wr(`AAU_OFS_CTL, 16'h00c0);
    ls_op(16'h2106, 5'h10, 1'b1);
    io_rd(`AAU_OFS_OPA, d); chk("map1_load", {16'h0, mw(3)}, {16'h0, d});
    io_rd(8'h05, d); chk("unmapped", 32'h0, {16'h0, d});
    end_of_test();
  end
endmodule
